// *** rtl/sprt_regs.svh ***
// timing counts and field positions for the serial port with shared data/ready pin
// assumes a 40 MHz system clock; included by bare name
//
// Behaviour
// RQ1: the serial clock's falling edge is the active edge, and output data changes on it.
// RQ2: the data/ready pin is driven only after chip select falls, and within 80 ns.
// RQ3: the data/ready pin is released within 10 to 80 ns after chip select rises.
// RQ4: the host leaves 3, 12 or 24 master clocks between operations by power mode.
// RQ5: a fresh result arriving while ready is still low pulses ready high for 6, 25 or 50 us.
// RQ6: without select hold, the pin turns from data to ready after the last rising clock edge.
// RQ7: with select hold, the pin keeps the last data bit until chip select rises.
// RQ8: without select hold, ready returns at least 10 ns, or 110 ns with the delay bit, after it.
// RQ9: ready goes high once the result has been read.
// RQ10: outside continuous read, the same result may be read again while ready is high.
// RQ11: the host does not repeat a read near the next result update.
// RQ12: in continuous read each result word can be read only once.
// RQ13: write data is sampled on the rising clock edge, most significant bit first.
// RQ14: chip select rising mid transfer abandons the partial transfer.
`ifndef SPRT_REGS_SVH
`define SPRT_REGS_SVH

`define SPRT_CLK_MHZ          40
`define SPRT_DATA_W           24
`define SPRT_CMD_W            8
`define SPRT_CMD_READ_BIT     6

// power mode codes
`define SPRT_PWR_FULL         2'h0
`define SPRT_PWR_MID          2'h1
`define SPRT_PWR_LOW          2'h2

// ready pulse lengths in microseconds, rounded down to cycles
`define SPRT_T13_FULL_US      6
`define SPRT_T13_MID_US       25
`define SPRT_T13_LOW_US       50
`define SPRT_T13_FULL_CYC     (`SPRT_T13_FULL_US * `SPRT_CLK_MHZ)
`define SPRT_T13_MID_CYC      (`SPRT_T13_MID_US * `SPRT_CLK_MHZ)
`define SPRT_T13_LOW_CYC      (`SPRT_T13_LOW_US * `SPRT_CLK_MHZ)

// least time from last rising clock to ready, rounded up to cycles
`define SPRT_T7_NS            10
`define SPRT_T7_DEL_NS        110
`define SPRT_T7_CYC           ((`SPRT_T7_NS * `SPRT_CLK_MHZ + 999) / 1000)
`define SPRT_T7_DEL_CYC       ((`SPRT_T7_DEL_NS * `SPRT_CLK_MHZ + 999) / 1000)

`define SPRT_PCNT_W           11
`define SPRT_TCNT_W           3

`endif

// *** rtl/sprt_pkg.sv ***
// types shared by the serial port design
// assumes nothing of its surroundings
package sprt_pkg;

    typedef enum logic [2:0] {
        SPRT_IDLE,
        SPRT_CMD,
        SPRT_WR,
        SPRT_DATA,
        SPRT_TAIL,
        SPRT_HOLD,
        SPRT_RDY
    } sprt_state_t;

endpackage

// *** rtl/sprt_sync.sv ***
// two flip-flop synchroniser for a group of asynchronous pins
// assumes inputs are single-bit levels, each crossed independently
`timescale 1ns/10ps
module sprt_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk_in,
    input  wire logic             arst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    initial begin
        if (WIDTH < 1) begin
            $error("sprt_sync: WIDTH must be at least 1");
        end
    end

    // reset to all ones so idle-high pins do not fake an edge after reset
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta     <= '1;
            sync_out <= '1;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// *** rtl/sprt_serial_port.sv ***
// serial port of a converter: command/write shifting and a shared data-out/ready pin
// assumes chip select, serial clock and data in come from an outside host, asynchronous
`timescale 1ns/10ps
`include "sprt_regs.svh"
module sprt_serial_port
    import sprt_pkg::*;
#(
    parameter int DATA_W = `SPRT_DATA_W
) (
    input  wire logic              sys_clk_in,
    input  wire logic              arst_n_in,
    // host pins
    input  wire logic              cs_n_in,
    input  wire logic              sclk_in,
    input  wire logic              din_in,
    output logic                   dout_rdy_out,
    output logic                   dout_rdy_oe_out,
    // converter side
    input  wire logic [DATA_W-1:0] result_in,
    input  wire logic              result_valid_in,
    input  wire logic [1:0]        power_mode_in,
    input  wire logic              select_hold_in,
    input  wire logic              ready_switch_delay_enable_in,
    input  wire logic              cont_read_in,
    // received bytes and ready flag
    output logic [7:0]             rx_byte_out,
    output logic                   rx_valid_out,
    output logic                   rx_cmd_out,
    output logic                   ready_n_out
);

    localparam int BCNT_W = $clog2(DATA_W + 1);

    initial begin
        if (DATA_W < `SPRT_CMD_W || DATA_W > 32) begin
            $error("sprt_serial_port: DATA_W must be 8 to 32");
        end
        // the pulse and tail counters must hold their longest loads
        if (`SPRT_T13_LOW_CYC >= (1 << `SPRT_PCNT_W)) begin
            $error("sprt_serial_port: ready pulse count does not fit");
        end
        if (`SPRT_T7_DEL_CYC >= (1 << `SPRT_TCNT_W)) begin
            $error("sprt_serial_port: tail count does not fit");
        end
    end

    // pin crossing
    logic [2:0] pins_sync;
    logic       cs_n_s;
    logic       sclk_s;
    logic       din_s;

    sprt_sync #(
        .WIDTH (3)
    ) u_sync (
        .sys_clk_in (sys_clk_in),
        .arst_n_in  (arst_n_in),
        .async_in   ({cs_n_in, sclk_in, din_in}),
        .sync_out   (pins_sync)
    );

    assign cs_n_s = pins_sync[2];
    assign sclk_s = pins_sync[1];
    assign din_s  = pins_sync[0];

    // state
    sprt_state_t               state;
    logic                      sclk_prev;
    logic [DATA_W-1:0]         result;
    logic [DATA_W-1:0]         shift;
    logic [BCNT_W-1:0]         bitcnt;
    logic [`SPRT_TCNT_W-1:0]   tail_cnt;
    logic [`SPRT_PCNT_W-1:0]   pulse_cnt;
    logic                      fresh;
    logic [`SPRT_CMD_W-1:0]    rx_sh;

    sprt_state_t               next_state;
    logic                      next_sclk_prev;
    logic [DATA_W-1:0]         next_result;
    logic [DATA_W-1:0]         next_shift;
    logic [BCNT_W-1:0]         next_bitcnt;
    logic [`SPRT_TCNT_W-1:0]   next_tail_cnt;
    logic [`SPRT_PCNT_W-1:0]   next_pulse_cnt;
    logic                      next_fresh;
    logic [`SPRT_CMD_W-1:0]    next_rx_sh;
    logic                      next_dout;
    logic                      next_oe;
    logic [7:0]                next_rx_byte;
    logic                      next_rx_valid;
    logic                      next_rx_cmd;

    // helper terms
    logic                      sclk_fall;
    logic                      sclk_rise;
    logic                      rdy_n;
    logic                      read_done;
    logic [`SPRT_PCNT_W-1:0]   pulse_len;
    logic [`SPRT_TCNT_W-1:0]   tail_len;
    logic [`SPRT_CMD_W-1:0]    rx_next_val;

    assign sclk_fall   = sclk_prev & ~sclk_s; // RQ1
    assign sclk_rise   = ~sclk_prev & sclk_s; // RQ13
    assign rdy_n       = ~fresh | (pulse_cnt != '0);
    assign ready_n_out = rdy_n;
    assign rx_next_val = {rx_sh[`SPRT_CMD_W-2:0], din_s};

    // ready pulse length by power mode; an unknown mode takes the longest
    always_comb begin
        case (power_mode_in)
            `SPRT_PWR_FULL: pulse_len = `SPRT_PCNT_W'(`SPRT_T13_FULL_CYC);
            `SPRT_PWR_MID:  pulse_len = `SPRT_PCNT_W'(`SPRT_T13_MID_CYC);
            default:        pulse_len = `SPRT_PCNT_W'(`SPRT_T13_LOW_CYC);
        endcase
    end

    // counted from the synchronised edge, so real spacing exceeds the least time
    assign tail_len = ready_switch_delay_enable_in ? `SPRT_TCNT_W'(`SPRT_T7_DEL_CYC)
                                                   : `SPRT_TCNT_W'(`SPRT_T7_CYC); // RQ8

    // last data bit taken on its rising edge
    assign read_done = (state == SPRT_DATA) && sclk_rise &&
                       (bitcnt == BCNT_W'(DATA_W - 1));

    // serial clock edge detector; idles high like the pin, so reset gives no false edge
    always_comb begin
        next_sclk_prev = sclk_s;
    end

    // edge detector register
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sclk_prev <= 1'b1;
        end else begin
            sclk_prev <= next_sclk_prev;
        end
    end

    // ready bookkeeping: held word, unread flag and forced-high pulse
    // a word arriving mid-read is not stored; it sets the flag and, over an unread word, forces a ready pulse; the read's end may clear it again
    always_comb begin
        next_result    = result;
        next_pulse_cnt = (pulse_cnt != '0) ? pulse_cnt - 1'b1 : pulse_cnt;
        next_fresh     = fresh;

        // a finished read marks the word taken
        if (read_done) begin
            next_fresh = 1'b0; // RQ9 RQ12
        end

        // new result: set beats the read's clear; an unread word forces a ready pulse
        if (result_valid_in) begin
            if (state != SPRT_DATA) begin
                next_result = result_in;
            end
            if (fresh && !read_done) begin
                next_pulse_cnt = pulse_len; // RQ5
            end
            next_fresh = 1'b1;
        end
    end

    // ready bookkeeping registers
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            result    <= '0;
            pulse_cnt <= '0;
            fresh     <= 1'b0;
        end else begin
            result    <= next_result;
            pulse_cnt <= next_pulse_cnt;
            fresh     <= next_fresh;
        end
    end

    // tail counter loads at the read's end and runs down to zero
    always_comb begin
        next_tail_cnt = tail_cnt;
        if (read_done) begin
            next_tail_cnt = tail_len; // RQ8
        end else if (tail_cnt != '0) begin
            next_tail_cnt = tail_cnt - 1'b1;
        end
    end

    // tail counter register
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tail_cnt <= '0;
        end else begin
            tail_cnt <= next_tail_cnt;
        end
    end

    // transfer and pin next-state logic
    always_comb begin
        next_state     = state;
        next_shift     = shift;
        next_bitcnt    = bitcnt;
        next_rx_sh     = rx_sh;
        next_dout      = dout_rdy_out;
        next_oe        = dout_rdy_oe_out;
        next_rx_byte   = rx_byte_out;
        next_rx_valid  = 1'b0;
        next_rx_cmd    = rx_cmd_out;

        case (state)
            SPRT_IDLE: begin
                next_oe     = 1'b0;
                next_bitcnt = '0;
                if (!cs_n_s) begin
                    next_oe   = 1'b1; // RQ2
                    next_dout = rdy_n;
                    next_shift = result;
                    if (cont_read_in) begin
                        // each word once only; a taken word gives no data phase
                        next_state = fresh ? SPRT_DATA : SPRT_RDY; // RQ12
                    end else begin
                        next_state = SPRT_CMD;
                    end
                end
            end
            SPRT_CMD, SPRT_WR: begin
                next_dout = rdy_n;
                if (sclk_rise) begin
                    next_rx_sh  = rx_next_val; // RQ13
                    next_bitcnt = bitcnt + 1'b1;
                    if (bitcnt == BCNT_W'(`SPRT_CMD_W - 1)) begin
                        next_bitcnt   = '0;
                        next_rx_byte  = rx_next_val;
                        next_rx_valid = 1'b1;
                        next_rx_cmd   = (state == SPRT_CMD);
                        if (state == SPRT_CMD && rx_next_val[`SPRT_CMD_READ_BIT]) begin
                            // rereading the held word is allowed while ready is high
                            next_shift = result; // RQ10
                            next_state = SPRT_DATA;
                        end else begin
                            next_state = SPRT_WR;
                        end
                    end
                end
            end
            SPRT_DATA: begin
                if (sclk_fall) begin
                    next_dout  = shift[DATA_W-1]; // RQ1
                    next_shift = {shift[DATA_W-2:0], 1'b0};
                end
                if (sclk_rise) begin
                    next_bitcnt = bitcnt + 1'b1;
                end
                if (read_done) begin
                    next_state = select_hold_in ? SPRT_HOLD : SPRT_TAIL; // RQ7
                end
            end
            SPRT_TAIL: begin
                if (tail_cnt <= `SPRT_TCNT_W'(1)) begin
                    next_state = SPRT_RDY; // RQ6 RQ8
                end
            end
            SPRT_HOLD: begin
                next_dout = dout_rdy_out; // RQ7
            end
            SPRT_RDY: begin
                next_dout = rdy_n; // RQ6
            end
            default: begin
                next_state = SPRT_IDLE;
            end
        endcase

        // select released: drop the pin and any partial transfer
        if (cs_n_s && state != SPRT_IDLE) begin
            next_state  = SPRT_IDLE; // RQ14
            next_oe     = 1'b0; // RQ3
            next_bitcnt = '0;
            next_rx_sh  = '0;
        end
    end

    // transfer and pin registers
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state           <= SPRT_IDLE;
            shift           <= '0;
            bitcnt          <= '0;
            rx_sh           <= '0;
            dout_rdy_out    <= 1'b1;
            dout_rdy_oe_out <= 1'b0;
            rx_byte_out     <= 8'h00;
            rx_valid_out    <= 1'b0;
            rx_cmd_out      <= 1'b0;
        end else begin
            state           <= next_state;
            shift           <= next_shift;
            bitcnt          <= next_bitcnt;
            rx_sh           <= next_rx_sh;
            dout_rdy_out    <= next_dout;
            dout_rdy_oe_out <= next_oe;
            rx_byte_out     <= next_rx_byte;
            rx_valid_out    <= next_rx_valid;
            rx_cmd_out      <= next_rx_cmd;
        end
    end

endmodule

// *** test/sprt_chk.sv ***
// assertions on the serial port pins and the ready flag
// assumes a host that idles sclk high and frames transfers with cs_n
`timescale 1ns/10ps
module sprt_chk (
    input wire logic       sys_clk_in,
    input wire logic       arst_n_in,
    input wire logic       cs_n_in,
    input wire logic       sclk_in,
    input wire logic       dout_rdy_out,
    input wire logic       dout_rdy_oe_out,
    input wire logic       result_valid_in,
    input wire logic [1:0] power_mode_in,
    input wire logic       select_hold_in,
    input wire logic       ready_switch_delay_enable_in,
    input wire logic       rx_valid_out,
    input wire logic       ready_n_out
);
    logic [5:0] cnt;
    logic [5:0] next_cnt;
    logic       sclk_q;
    // sclk rises seen in this frame; 32 marks the end of a read outside continuous read (24 there)
    always_comb begin
        next_cnt = cs_n_in ? 6'h00 : cnt + {5'h00, sclk_in & ~sclk_q};
    end
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cnt    <= 6'h00;
            sclk_q <= 1'b1;
        end else begin
            cnt    <= next_cnt;
            sclk_q <= sclk_in;
        end
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);
    AST_OE_ON: assert property ($fell(cs_n_in) |-> ##[1:5] dout_rdy_oe_out)
        else $error("pin not driven after select");
    AST_OE_EARLY: assert property (cs_n_in && !dout_rdy_oe_out |=> !dout_rdy_oe_out)
        else $error("pin driven without select");
    AST_OE_OFF: assert property ($rose(cs_n_in) |-> ##[1:5] !dout_rdy_oe_out)
        else $error("pin not released");
    AST_OE_HOLD: assert property ($rose(cs_n_in) && $past(dout_rdy_oe_out) |-> dout_rdy_oe_out)
        else $error("pin released too soon");
    AST_RDY_PULSE: assert property (result_valid_in && !ready_n_out && power_mode_in == 2'h0
        |=> ready_n_out [*8] ##232 ready_n_out ##1 !ready_n_out)
        else $error("ready pulse length wrong");
    AST_RX_FRAME: assert property (rx_valid_out |-> !$past(cs_n_in, 4))
        else $error("byte outside a frame");
    AST_HOLD_LSB: assert property (select_hold_in && !cs_n_in && cnt == 6'h20
        && $past(cnt) == 6'h20 |-> $stable(dout_rdy_out))
        else $error("last bit not held");
    AST_TO_RDY: assert property (!select_hold_in && $rose(cnt == 6'h20)
        |-> ##[1:10] dout_rdy_out == ready_n_out)
        else $error("pin did not turn to ready");
    AST_TAIL_DEL: assert property (!select_hold_in && ready_switch_delay_enable_in
        && $rose(cnt == 6'h20) |-> $stable(dout_rdy_out) [*6])
        else $error("ready switch too early");
    cover property ($rose(cnt == 6'h20) && select_hold_in);
    cover property (result_valid_in && !ready_n_out);
    cover property (rx_valid_out);
endmodule

bind sprt_serial_port sprt_chk chk_u (.sys_clk_in, .arst_n_in, .cs_n_in, .sclk_in,
    .dout_rdy_out, .dout_rdy_oe_out, .result_valid_in, .power_mode_in, .select_hold_in,
    .ready_switch_delay_enable_in, .rx_valid_out, .ready_n_out);

// *** test/sprt_host.sv ***
// host side model: frames transfers with chip select and a 200 ns serial clock
// assumes callers enter its tasks just after a system clock edge
`timescale 1ns/10ps
module sprt_host (
    input  wire logic sys_clk_in,
    input  wire logic pin_in,
    output logic      cs_n_out,
    output logic      sclk_out,
    output logic      din_out
);
    localparam int GAP = 24; // widest spacing, safe in every power mode
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b1;
        din_out  = 1'b1;
    end
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk_in);
        #1;
    endtask
    // n bits msb first; the pin is sampled just before each rising sclk
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        cs_n_out = 1'b0;
        tick(4);
        for (int i = 0; i < n; i++) begin
            sclk_out = 1'b0;
            din_out  = tx[n-1-i];
            tick(4);
            rx = {rx[30:0], pin_in};
            sclk_out = 1'b1;
            tick(4);
        end
        tick(8);
        cs_n_out = 1'b1;
        din_out  = ~din_out; // released line shows no stale bit
        tick(GAP);
    endtask
endmodule

// *** test/tb_sprt_serial_port.sv ***
// self-checking bench for the serial port with shared data/ready pin
// assumes the host model in sprt_host and the checker bound in sprt_chk
`timescale 1ns/10ps
module tb_sprt_serial_port;
    logic        clk = 1'b0;
    logic        rst_n, cs_n, sclk, din, dout, oe, pin, rv, sh, dly, cr, rxv, rxc, rdyn;
    logic [23:0] res, w;
    logic [1:0]  pm;
    logic [7:0]  rxb;
    logic [31:0] rx;
    int          err_count = 0;
    int          cmp_count = 0;
    int          n;
    // the pin floats while the port does not drive it
    always #12.5 clk = ~clk;
    assign pin = oe ? dout : 1'bz;
    sprt_host host_u (.sys_clk_in(clk), .pin_in(pin), .cs_n_out(cs_n), .sclk_out(sclk),
        .din_out(din));
    sprt_serial_port dut_u (.sys_clk_in(clk), .arst_n_in(rst_n), .cs_n_in(cs_n),
        .sclk_in(sclk), .din_in(din), .dout_rdy_out(dout), .dout_rdy_oe_out(oe),
        .result_in(res), .result_valid_in(rv), .power_mode_in(pm), .select_hold_in(sh),
        .ready_switch_delay_enable_in(dly), .cont_read_in(cr), .rx_byte_out(rxb),
        .rx_valid_out(rxv), .rx_cmd_out(rxc), .ready_n_out(rdyn));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        if (err_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic put(input logic [23:0] v);
        res = v;
        rv = 1'b1;
        host_u.tick(1);
        rv = 1'b0;
    endtask
    task automatic rd(input int k);
        host_u.xfer({8'h40, 24'h0}, k, rx);
    endtask
    initial begin
        {rst_n, rv, sh, dly, cr, res, pm} = '0;
        host_u.tick(6);
        rst_n = 1'b1;
        host_u.tick(3);
        // plain, delayed-switch and held-last-bit reads, each read twice
        for (int k = 0; k < 3; k++) begin
            sh  = (k == 2);
            dly = (k == 1);
            w   = 24'ha5c3f0 ^ {16'h0, k[3:0], 4'h0};
            put(w);
            chk(rdyn, 1'b0);
            rd(32);
            chk(rx, {8'h00, w});
            chk({rxc, rxb}, 9'h140);
            chk(rdyn, 1'b1);
            rd(32);
            chk(rx, {8'hff, w});
        end
        // write with a trailing partial byte, then an abandoned command
        host_u.xfer({12'h0, 8'h05, 8'h9b, 4'h6}, 20, rx);
        chk({rxc, rxb}, 9'h09b);
        host_u.xfer(32'h1f, 5, rx);
        chk(rxb, 8'h9b);
        host_u.xfer(32'h0c, 8, rx);
        chk({rxc, rxb}, 9'h10c);
        // a new result over an unread one stretches ready high per power mode
        // code 3 is served as low power
        for (int m = 0; m < 4; m++) begin
            pm = m[1:0];
            put(24'h111111);
            host_u.tick(1);
            w = 24'h2468a0 ^ {22'h0, m[1:0]};
            put(w);
            n = 0;
            while (rdyn === 1'b1 && n < 3000) begin
                host_u.tick(1);
                n++;
            end
            chk(n, m == 0 ? 240 : m == 1 ? 1000 : 2000);
            if (n == 3000) summarize;
            rd(32);
            chk(rx[23:0], w);
        end
        // continuous read hands each word out once
        pm = 2'h0;
        cr = 1'b1;
        put(24'h0f1e2d);
        rd(24);
        chk(rx[23:0], 24'h0f1e2d);
        rd(24);
        chk(rx[23:0], 24'hffffff);
        summarize;
    end
endmodule
